/* core/fwd_pkg.sv */
// constants for the switch queue and forwarding policy block
package fwd_pkg;
  localparam int CLK_MHZ    = 200;
  localparam int UNIT_MS    = 2;                          // delay unit in ms
  localparam int UNIT_CYC   = UNIT_MS * 1000 * CLK_MHZ;   // cycles per unit
  localparam int SEC_UNITS  = 1000 / UNIT_MS;             // units per second
  localparam int AGE_MIN_S  = 300;
  localparam int AGE_MAX_S  = 765;
  localparam int AGE_DEF_S  = 300;
  localparam int RETRY_MAX  = 48;
  localparam int IFG_BASE   = 12;                         // gap cycles
  localparam int IFG_COMP   = 4;                          // extra gap cycles
  localparam int NPORT      = 4;
  localparam int QDEPTH     = 4;
  localparam int TBL_SIZE   = 8;
  localparam int STORM_WIN  = 1000;                       // window cycles
  localparam int STORM_STEP = 2;                          // frames per 5 pct
  localparam logic [1:0] SCH_FCFS   = 2'h0;
  localparam logic [1:0] SCH_STRICT = 2'h1;
  localparam logic [1:0] SCH_WRR    = 2'h2;
  localparam logic [1:0] BND_OFF    = 2'h0;
  localparam logic [1:0] BND_1S     = 2'h1;
  localparam logic [1:0] BND_2S     = 2'h2;
  localparam logic [1:0] BND_4S     = 2'h3;
endpackage

/* core/fwd_policy.sv */
// forwarding policy core: ageing, delay bounds, storm control, scheduling
module fwd_policy
  import fwd_pkg::*;
#(
  parameter int UNIT_CYCLES = UNIT_CYC
)(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_age_en,
  input  wire logic [9:0]  i_age_time,
  input  wire logic [1:0]  i_bridge_bound,
  input  wire logic        i_low_bound_en,
  input  wire logic [7:0]  i_low_max_delay,
  input  wire logic [2:0]  i_storm_sel,
  input  wire logic [1:0]  i_sched_mode,
  input  wire logic [2:0]  i_wrr_ratio,
  input  wire logic [7:0]  i_prio_high_map,
  input  wire logic        i_half_duplex,
  input  wire logic        i_retry_forever,
  input  wire logic        i_hash_crc,
  input  wire logic        i_ifg_comp_en,
  input  wire logic        i_learn_valid,
  input  wire logic [47:0] i_learn_mac,
  input  wire logic [47:0] i_look_mac,
  input  wire logic        i_rx_valid,
  input  wire logic [1:0]  i_rx_port,
  input  wire logic        i_rx_bcast,
  input  wire logic [2:0]  i_rx_prio,
  input  wire logic [7:0]  i_rx_tag,
  input  wire logic        i_tx_ready,
  input  wire logic        i_tx_collision,
  output logic             o_rx_ready,
  output logic             o_rx_storm_drop,
  output logic [NPORT-1:0] o_storm_active,
  output logic             o_look_hit,
  output logic             o_tx_valid,
  output logic [7:0]       o_tx_tag,
  output logic             o_delay_drop,
  output logic             o_col_drop
);
  // table index: folded crc-style xor or the low address bits
  function automatic logic [2:0] tbl_index(input logic [47:0] mac, input logic crc);
    logic [2:0] f;
    f = 3'h0;
    for (int i = 0; i < 16; i++)
      f = {f[1:0], f[2]} ^ mac[i*3 +: 3];
    return crc ? f : mac[2:0];
  endfunction

  // time base: unit ticks every 2 ms, second ticks every 500 units
  logic [18:0] unit_cnt;
  logic [8:0]  sec_cnt;
  logic [11:0] now;
  wire unit_tick = (unit_cnt == 19'(UNIT_CYCLES - 1));
  wire sec_tick  = unit_tick && (sec_cnt == 9'(SEC_UNITS - 1));
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      unit_cnt <= 19'h0;
      sec_cnt  <= 9'h0;
      now      <= 12'h0;
    end
    else
    begin
      unit_cnt <= unit_tick ? 19'h0 : unit_cnt + 19'h1;
      if (unit_tick)
      begin
        sec_cnt <= sec_tick ? 9'h0 : sec_cnt + 9'h1;
        now     <= now + 12'h1;
      end
    end
  end

  // address table with per-entry idle seconds
  logic        tv [TBL_SIZE];
  logic [47:0] tmac [TBL_SIZE];
  logic [9:0]  tage [TBL_SIZE];
  wire  [2:0]  learn_idx = tbl_index(i_learn_mac, i_hash_crc);
  wire  [2:0]  look_idx  = tbl_index(i_look_mac, i_hash_crc);
  // out-of-range settings clamp so an entry can never stick forever
  wire  [9:0]  age_lim = (i_age_time < 10'(AGE_MIN_S)) ? 10'(AGE_MIN_S) :
                         (i_age_time > 10'(AGE_MAX_S)) ? 10'(AGE_MAX_S) : i_age_time;
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_look_hit <= 1'b0;
      for (int i = 0; i < TBL_SIZE; i++)
      begin
        tv[i]   <= 1'b0;
        tmac[i] <= 48'h0;
        tage[i] <= 10'h0;
      end
    end
    else
    begin
      o_look_hit <= tv[look_idx] && (tmac[look_idx] == i_look_mac);
      for (int i = 0; i < TBL_SIZE; i++)
      begin
        if (sec_tick && tv[i])
        begin
          tage[i] <= tage[i] + 10'h1;
          if (i_age_en && tage[i] >= age_lim)
            tv[i] <= 1'b0;
        end
        if (i_learn_valid && learn_idx == 3'(i))
        begin
          tv[i]   <= 1'b1; // a fresh learn wins over removal
          tmac[i] <= i_learn_mac;
          tage[i] <= 10'h0;
        end
      end
    end
  end

  // storm control: budget of broadcasts per port per window
  logic [9:0] win_cnt;
  logic [7:0] bc_cnt [NPORT];
  wire  [7:0] budget   = 8'(i_storm_sel) * 8'(STORM_STEP);
  wire        storm_on = (i_storm_sel != 3'h0) && (i_storm_sel <= 3'h5);
  wire        win_end  = (win_cnt == 10'(STORM_WIN - 1));
  wire        over     = storm_on && i_rx_bcast && (bc_cnt[i_rx_port] >= budget);
  wire        to_high  = i_prio_high_map[i_rx_prio];
  always_comb
  begin
    for (int p = 0; p < NPORT; p++)
      o_storm_active[p] = storm_on && (bc_cnt[p] >= budget);
  end

  // two priority queues of tag and arrival stamp
  logic [7:0]  qtag [2][QDEPTH];
  logic [11:0] qts  [2][QDEPTH];
  logic [3:0]  qseq [2][QDEPTH];
  logic [3:0]  arr_cnt;
  logic [2:0]  qwp  [2];
  logic [2:0]  qrp  [2];
  wire hne = (qwp[1] != qrp[1]);
  wire lne = (qwp[0] != qrp[0]);
  wire hfull = (qwp[1] - qrp[1]) == 3'(QDEPTH);
  wire lfull = (qwp[0] - qrp[0]) == 3'(QDEPTH);
  wire [11:0] hage = now - qts[1][qrp[1][1:0]];
  wire [11:0] lage = now - qts[0][qrp[0][1:0]];
  assign o_rx_ready = to_high ? !hfull : !lfull;
  wire rx_take = i_rx_valid && o_rx_ready && !over;
  assign o_rx_storm_drop = i_rx_valid && over;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      win_cnt <= 10'h0;
      for (int p = 0; p < NPORT; p++)
        bc_cnt[p] <= 8'h0;
    end
    else
    begin
      win_cnt <= win_end ? 10'h0 : win_cnt + 10'h1;
      for (int p = 0; p < NPORT; p++)
        if (win_end)
          bc_cnt[p] <= 8'h0;
        // an offer counts once, on the edge that ends it, so a held broadcast is not counted twice
        else if (i_rx_valid && i_rx_bcast && o_rx_ready && i_rx_port == 2'(p) && bc_cnt[p] != 8'hff)
          bc_cnt[p] <= bc_cnt[p] + 8'h1;
    end
  end

  // delay bounds in 2 ms units
  wire [11:0] bridge_lim = (i_bridge_bound == BND_1S) ? 12'(SEC_UNITS) :
                           (i_bridge_bound == BND_2S) ? 12'(2 * SEC_UNITS) : 12'(4 * SEC_UNITS);
  wire bridge_on  = (i_bridge_bound != BND_OFF);
  wire h_expire   = bridge_on && hne && (hage > bridge_lim);
  wire l_expire   = bridge_on && lne && (lage > bridge_lim);
  wire low_urgent = bridge_on && i_low_bound_en && lne && (i_low_max_delay != 8'h0)
                    && (lage > 12'(i_low_max_delay));

  // scheduler choice
  logic [2:0] wcnt;
  logic       buf_room;
  wire wrr_low  = !hne || (wcnt >= i_wrr_ratio);
  // stamps are coarse, so inside one unit the arrival number decides; in fcfs use the
  // queued frames are the latest arrivals, which keeps the 4-bit gap from wrapping
  wire [3:0] seq_gap = qseq[1][qrp[1][1:0]] - qseq[0][qrp[0][1:0]];
  wire older_lo = (lage != hage) ? (lage > hage) : (seq_gap != 4'h0 && !seq_gap[3]);
  wire pick_low = low_urgent ? 1'b1 :
                  (i_sched_mode == SCH_FCFS) ? (!hne || (lne && older_lo)) :
                  (i_sched_mode == SCH_WRR)  ? (lne && wrr_low) :
                  !hne;
  wire do_drop  = h_expire || l_expire;
  wire sel_push = !do_drop && buf_room && (hne || lne);
  wire sel_q    = !pick_low;
  assign o_delay_drop = do_drop;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      wcnt <= 3'h0;
      arr_cnt <= 4'h0;
      for (int q = 0; q < 2; q++)
      begin
        qwp[q] <= 3'h0;
        qrp[q] <= 3'h0;
        for (int e = 0; e < QDEPTH; e++)
        begin
          qtag[q][e] <= 8'h0;
          qts[q][e]  <= 12'h0;
          qseq[q][e] <= 4'h0;
        end
      end
    end
    else
    begin
      if (rx_take)
      begin
        qtag[to_high][qwp[to_high][1:0]] <= i_rx_tag;
        qts[to_high][qwp[to_high][1:0]]  <= now;
        qseq[to_high][qwp[to_high][1:0]] <= arr_cnt;
        qwp[to_high] <= qwp[to_high] + 3'h1;
        arr_cnt <= arr_cnt + 4'h1;
      end
      if (h_expire)
        qrp[1] <= qrp[1] + 3'h1;
      else if (l_expire)
        qrp[0] <= qrp[0] + 3'h1;
      else if (sel_push)
        qrp[sel_q] <= qrp[sel_q] + 3'h1;
      if (sel_push)
        wcnt <= sel_q ? wcnt + 3'h1 : 3'h0;
    end
  end

  // two-entry output buffer; head is the frame on the wire
  logic [7:0] btag [2];
  logic [1:0] bcnt;
  logic       brp;
  logic [5:0] retries;
  logic [4:0] gap;
  assign buf_room = (bcnt != 2'h2);
  wire tx_busy  = (gap != 5'h0);
  assign o_tx_valid = (bcnt != 2'h0) && !tx_busy && !i_tx_collision;
  assign o_tx_tag   = btag[brp];
  wire tx_done  = o_tx_valid && i_tx_ready;
  wire col      = (bcnt != 2'h0) && !tx_busy && i_tx_collision && i_half_duplex;
  wire col_give = col && !i_retry_forever && (retries == 6'(RETRY_MAX));
  wire pop      = tx_done || col_give;
  assign o_col_drop = col_give;
  wire [1:0] bwp = 2'(brp) + bcnt;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      btag[0] <= 8'h0;
      btag[1] <= 8'h0;
      bcnt    <= 2'h0;
      brp     <= 1'b0;
      retries <= 6'h0;
      gap     <= 5'h0;
    end
    else
    begin
      if (sel_push)
        btag[bwp[0]] <= qtag[sel_q][qrp[sel_q][1:0]];
      bcnt <= bcnt + {1'b0, sel_push} - {1'b0, pop};
      if (pop)
        brp <= !brp;
      // retry count saturates so forever mode cannot wrap it
      if (pop)
        retries <= 6'h0;
      else if (col && retries != 6'h3f)
        retries <= retries + 6'h1;
      if (pop || col)
        gap <= i_ifg_comp_en ? 5'(IFG_BASE + IFG_COMP) : 5'(IFG_BASE);
      else if (tx_busy)
        gap <= gap - 5'h1;
    end
  end

  // checks on the scheduling and drop logic
  AST_COL_LIMIT: assert property (@(posedge i_clk) disable iff (i_rst)
    o_col_drop |-> (retries == 6'(RETRY_MAX)) && i_half_duplex)
    else $error("collision drop before retry limit");
  AST_FOREVER: assert property (@(posedge i_clk) disable iff (i_rst)
    i_retry_forever |-> !o_col_drop)
    else $error("drop while retrying forever");
  AST_STRICT: assert property (@(posedge i_clk) disable iff (i_rst)
    (sel_push && i_sched_mode == SCH_STRICT && hne && !low_urgent) |-> sel_q)
    else $error("low sent while high waits");
  AST_FCFS: assert property (@(posedge i_clk) disable iff (i_rst)
    (sel_push && i_sched_mode == SCH_FCFS && hne && lne && !low_urgent && older_lo) |-> !sel_q)
    else $error("fcfs skipped older frame");
  AST_WRR: assert property (@(posedge i_clk) disable iff (i_rst)
    (sel_push && i_sched_mode == SCH_WRR && !sel_q && hne && !low_urgent) |-> wcnt >= i_wrr_ratio)
    else $error("low sent before ratio met");
  AST_WRR_RESTART: assert property (@(posedge i_clk) disable iff (i_rst)
    (sel_push && !sel_q) |=> (wcnt == 3'h0))
    else $error("high count not restarted");
  AST_BRIDGE: assert property (@(posedge i_clk) disable iff (i_rst)
    o_delay_drop |-> bridge_on && ((hne && hage > bridge_lim) || (lne && lage > bridge_lim)))
    else $error("drop without expiry");
  AST_LOW_NEEDS_BRIDGE: assert property (@(posedge i_clk) disable iff (i_rst)
    low_urgent |-> bridge_on && i_low_bound_en)
    else $error("low bound used without bridge bound");
  AST_STORM: assert property (@(posedge i_clk) disable iff (i_rst)
    o_rx_storm_drop |-> storm_on && i_rx_bcast && o_storm_active[i_rx_port])
    else $error("broadcast dropped under budget");
  AST_GAP: assert property (@(posedge i_clk) disable iff (i_rst)
    (tx_done && !i_ifg_comp_en) |=> !o_tx_valid [*8])
    else $error("gap too short after frame");
  COV_WRR: cover property (@(posedge i_clk) disable iff (i_rst)
    sel_push && !sel_q && hne && i_sched_mode == SCH_WRR);
  COV_COL_DROP: cover property (@(posedge i_clk) disable iff (i_rst) o_col_drop);
  COV_DELAY_DROP: cover property (@(posedge i_clk) disable iff (i_rst) o_delay_drop);
  COV_STORM: cover property (@(posedge i_clk) disable iff (i_rst) o_rx_storm_drop);
endmodule

/* tb/link_partner.sv */
// transmit-side link partner: takes frames, can stall and can collide
module link_partner (
  input  wire logic       i_clk,
  input  wire logic       i_valid,
  input  wire logic [7:0] i_tag,
  input  wire logic       i_stall,
  output logic            o_ready,
  output logic            o_collision
);
  timeunit 1ns;
  timeprecision 1ps;
  int         col_left = 0;
  logic       stall_q = 1'b1;
  // stall is taken at the rising edge, so a change made at the falling edge never races the model
  always @(posedge i_clk)
    stall_q <= i_stall;
  logic [7:0] got [$];
  realtime    got_t [$];
  initial
  begin
    o_ready = 1'b0;
    o_collision = 1'b0;
  end
  // act at the falling edge; a collision cycle withholds ready
  always @(negedge i_clk)
  begin
    o_collision <= i_valid && col_left > 0;
    o_ready <= !stall_q && !(i_valid && col_left > 0);
    if (i_valid && col_left > 0)
      col_left <= col_left - 1;
  end
  // log each frame taken and when
  always @(posedge i_clk)
    if (i_valid && o_ready)
    begin
      got.push_back(i_tag);
      got_t.push_back($realtime);
    end
endmodule

/* tb/testbench.sv */
// self-checking bench for the forwarding policy core
module testbench;
  import fwd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_rst, i_age_en, i_low_bound_en, i_half_duplex, i_retry_forever, i_hash_crc, i_ifg_comp_en;
  logic i_learn_valid, i_rx_valid, i_rx_bcast, i_tx_ready, i_tx_collision, stall, d;
  logic o_rx_ready, o_rx_storm_drop, o_look_hit, o_tx_valid, o_delay_drop, o_col_drop;
  logic [9:0]       i_age_time;
  logic [1:0]       i_bridge_bound, i_sched_mode, i_rx_port;
  logic [7:0]       i_low_max_delay, i_prio_high_map, i_rx_tag, o_tx_tag;
  logic [2:0]       i_storm_sel, i_wrr_ratio, i_rx_prio;
  logic [47:0]      i_learn_mac, i_look_mac;
  logic [NPORT-1:0] o_storm_active;
  int               failures = 0, check_count = 0, col_drops = 0, k, s;
  typedef struct packed {
    logic [1:0] m; logic [2:0] r; logic [7:0] map; logic [2:0] fp; logic [1:0] br; logic le;
    logic [0:3][2:0] p; logic [0:3][7:0] e;
  } row_t;
  // mode, ratio, map, filler prio, bridge, low bound, prios, expected tag order
  row_t rows [7] = '{
    '{SCH_FCFS, 3'h0, 8'hf0, 3'h0, BND_OFF, 1'b0, {3'h0, 3'h7, 3'h0, 3'h7}, 32'h01020304},
    '{SCH_STRICT, 3'h0, 8'hf0, 3'h0, BND_OFF, 1'b0, {3'h0, 3'h7, 3'h0, 3'h7}, 32'h02040103},
    '{SCH_WRR, 3'h2, 8'hf0, 3'h0, BND_OFF, 1'b0, {3'h0, 3'h7, 3'h7, 3'h7}, 32'h02030104},
    '{SCH_WRR, 3'h1, 8'hf0, 3'h0, BND_OFF, 1'b0, {3'h0, 3'h0, 3'h7, 3'h7}, 32'h03010402},
    '{SCH_STRICT, 3'h0, 8'h01, 3'h1, BND_OFF, 1'b0, {3'h7, 3'h0, 3'h3, 3'h0}, 32'h02040103},
    '{SCH_STRICT, 3'h0, 8'hf0, 3'h0, BND_1S, 1'b1, {3'h0, 3'h7, 3'h0, 3'h7}, 32'h01030204},
    '{SCH_STRICT, 3'h0, 8'hf0, 3'h0, BND_OFF, 1'b1, {3'h0, 3'h7, 3'h0, 3'h7}, 32'h02040103}};
  fwd_policy #(.UNIT_CYCLES(4)) DUT (.i_clk, .i_rst, .i_age_en, .i_age_time, .i_bridge_bound, .i_low_bound_en,
    .i_low_max_delay, .i_storm_sel, .i_sched_mode, .i_wrr_ratio, .i_prio_high_map, .i_half_duplex, .i_retry_forever,
    .i_hash_crc, .i_ifg_comp_en, .i_learn_valid, .i_learn_mac, .i_look_mac, .i_rx_valid, .i_rx_port, .i_rx_bcast,
    .i_rx_prio, .i_rx_tag, .i_tx_ready, .i_tx_collision, .o_rx_ready, .o_rx_storm_drop, .o_storm_active,
    .o_look_hit, .o_tx_valid, .o_tx_tag, .o_delay_drop, .o_col_drop);
  link_partner pm (.i_clk, .i_valid(o_tx_valid), .i_tag(o_tx_tag), .i_stall(stall), .o_ready(i_tx_ready),
    .o_collision(i_tx_collision));
  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // count discard pulses as they are raised
  always @(posedge i_clk)
    if (o_col_drop === 1'b1)
      col_drops++;
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    if (failures == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic timeout();
    chk("wait bound", 0, 1);
    end_of_test();
  endtask
  // offer one descriptor; valid stays up so bursts run back to back
  task automatic send(input logic [1:0] pt, input logic bc, input logic [2:0] pr, input logic [7:0] tg);
    int n;
    i_rx_port = pt;
    i_rx_bcast = bc;
    i_rx_prio = pr;
    i_rx_tag = tg;
    i_rx_valid = 1'b1;
    #1 d = o_rx_storm_drop;
    for (n = 0; n < 50 && o_rx_ready !== 1'b1; n++)
      @(negedge i_clk);
    if (n == 50)
      timeout();
    @(negedge i_clk);
  endtask
  task automatic wait_got(input int n);
    int c;
    for (c = 0; c < 400 && pm.got.size() < n; c++)
      @(negedge i_clk);
    if (c == 400)
      timeout();
  endtask
  // fillers occupy the buffer first, so the scheduler sees all four test frames at once
  task automatic run_row(input row_t w, input logic ifg);
    {i_sched_mode, i_wrr_ratio, i_prio_high_map} = {w.m, w.r, w.map};
    {i_bridge_bound, i_low_bound_en, i_ifg_comp_en} = {w.br, w.le, ifg};
    stall = 1'b1;
    pm.got.delete();
    pm.got_t.delete();
    send(2'h0, 1'b0, w.fp, 8'hf0);
    send(2'h0, 1'b0, w.fp, 8'hf1);
    i_rx_valid = 1'b0;
    repeat (5) @(negedge i_clk);
    for (k = 0; k < 4; k++)
      send(2'h0, 1'b0, w.p[k], 8'(k + 1));
    i_rx_valid = 1'b0;
    repeat (100) @(negedge i_clk);
    stall = 1'b0;
    wait_got(6);
    for (k = 0; k < 4; k++)
      chk("order", w.e[k], pm.got[k + 2]);
    for (k = 3; k < 6; k++)
      chk("gap", ifg ? 17 : 13, int'((pm.got_t[k] - pm.got_t[k - 1]) / 5.0));
  endtask
  task automatic run_col(input logic fv, input int n, input int ed);
    int c;
    i_retry_forever = fv;
    col_drops = 0;
    pm.got.delete();
    pm.col_left = n;
    send(2'h0, 1'b0, 3'h7, 8'hc0);
    i_rx_valid = 1'b0;
    for (c = 0; c < 1200 && pm.got.size() == 0 && col_drops == 0; c++)
      @(negedge i_clk);
    if (c == 1200)
      timeout();
    repeat (20) @(negedge i_clk);
    chk("col drops", ed, col_drops);
    chk("delivered", 1 - ed, pm.got.size());
  endtask
  // broadcasts spaced 14 cycles, inside the 16-cycle compensated gap, but too few per burst to fill the queue
  task automatic bcast(input logic e);
    send(2'h1, 1'b1, 3'h0, 8'hb0);
    if (e !== 1'bx)
      chk("storm drop", e, d);
    i_rx_valid = 1'b0;
    repeat (13) @(negedge i_clk);
  endtask
  task automatic wait_quiet();
    int c;
    for (c = 0; c < 1100 && o_storm_active[1] !== 1'b0; c++)
      @(negedge i_clk);
    if (c == 1100)
      timeout();
  endtask
  initial
  begin
    {i_age_en, i_low_bound_en, i_retry_forever, i_hash_crc, i_ifg_comp_en, i_learn_valid, i_rx_valid} = '0;
    {i_rx_bcast, i_bridge_bound, i_sched_mode, i_rx_port, i_prio_high_map, i_rx_tag} = '0;
    {i_storm_sel, i_wrr_ratio, i_rx_prio, i_learn_mac, i_look_mac} = '0;
    {i_rst, stall, i_half_duplex, i_age_en, i_age_time, i_low_max_delay} = {4'hf, 10'h12c, 8'h01};
    repeat (12) @(negedge i_clk);
    i_rst = 1'b0;
    chk("reset tx valid", 0, o_tx_valid);
    chk("reset rx ready", 1, o_rx_ready);
    chk("reset storm", 0, o_storm_active);
    for (s = 0; s < 7; s++)
      run_row(rows[s], 1'b0);
    run_row(rows[0], 1'b1);
    run_col(1'b0, 49, 1);
    run_col(1'b0, 48, 0);
    run_col(1'b1, 60, 0);
    // full duplex: a collision only masks the attempt, no retry count and no discard
    i_half_duplex = 1'b0;
    run_col(1'b0, 3, 0);
    pm.col_left = 0;
    i_half_duplex = 1'b1;
    // frames held past each bridge bound leave the queue; the two in the buffer survive
    for (s = 1; s < 4; s++)
    begin
      {i_bridge_bound, i_low_bound_en, stall} = {2'(s), 2'b01};
      pm.got.delete();
      for (k = 0; k < 3; k++)
        send(2'h0, 1'b0, 3'h7, 8'ha0);
      i_rx_valid = 1'b0;
      for (k = 0; k < 9000 && o_delay_drop !== 1'b1; k++)
        @(negedge i_clk);
      if (k == 9000)
        timeout();
      chk("drop time", 1, k >= 4 * (SEC_UNITS << (s - 1)) - 1 && k <= 4 * (SEC_UNITS << (s - 1)) + 4);
      stall = 1'b0;
      repeat (60) @(negedge i_clk);
      chk("kept", 2, pm.got.size());
    end
    // each budget is measured from a window start found by the storm flag falling
    {i_bridge_bound, i_storm_sel} = {BND_OFF, 3'h1};
    for (k = 0; k < 6 && o_storm_active[1] !== 1'b1; k++)
      bcast(1'bx);
    for (s = 1; s < 6; s++)
    begin
      wait_quiet();
      i_storm_sel = 3'(s);
      for (k = 0; k < 2 * s; k++)
        bcast(1'b0);
      chk("storm on", 1, o_storm_active[1]);
      bcast(1'b1);
    end
    wait_quiet();
    i_storm_sel = 3'h0;
    repeat (3) bcast(1'b0);
    // learned addresses hit one cycle later under both index schemes
    for (s = 0; s < 2; s++)
    begin
      i_hash_crc = s[0];
      i_learn_mac = 48'h0a0b0c0d0e00 + 48'(s);
      i_learn_valid = 1'b1;
      @(negedge i_clk);
      i_learn_valid = 1'b0;
      i_look_mac = i_learn_mac;
      @(negedge i_clk);
      chk("hit", 1, o_look_hit);
      i_look_mac = i_learn_mac + 48'h8;
      @(negedge i_clk);
      chk("miss", 0, o_look_hit);
    end
    // a reset in mid-run empties queues, buffer and address table
    i_look_mac = i_learn_mac;
    stall = 1'b1;
    send(2'h0, 1'b0, 3'h7, 8'hd0);
    send(2'h0, 1'b0, 3'h0, 8'hd1);
    i_rx_valid = 1'b0;
    i_rst = 1'b1;
    repeat (2) @(negedge i_clk);
    i_rst = 1'b0;
    pm.got.delete();
    chk("reset tx valid", 0, o_tx_valid);
    chk("reset rx ready", 1, o_rx_ready);
    chk("reset hit", 0, o_look_hit);
    stall = 1'b0;
    repeat (30) @(negedge i_clk);
    chk("reset hit", 0, o_look_hit);
    chk("reset kept", 0, pm.got.size());
    end_of_test();
  end
endmodule
